/* verilog/ssps_pkg.sv */
package ssps_pkg;

	// register byte addresses on the AHB-Lite slave
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DATA = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] ADDR_SYNC_SERIAL_STATUS = 8'h94;

	// control register field positions
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_ENABLE_BIT = 1;
	localparam int CTRL_ADDR_LSB = 8;

	// reset values
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [2:0] IRQ_RESET = 3'h0;

	// event positions in the interrupt registers
	localparam int IRQ_BYTE_BIT = 0;
	localparam int IRQ_START_BIT = 1;
	localparam int IRQ_STOP_BIT = 2;
	localparam int IRQ_COUNT = 3;

	localparam int SYNC_STAGES = 2;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// protocol selection
	typedef enum logic {
		SSPS_MODE_SPI = 1'b0,
		SSPS_MODE_I2C = 1'b1
	} ssps_mode_t;

	// i2c slave receive states
	typedef enum logic [2:0] {
		SSPS_IDLE = 3'b000,
		SSPS_ADDR = 3'b001,
		SSPS_ACK_WAIT = 3'b010,
		SSPS_ACK_HOLD = 3'b011,
		SSPS_DATA = 3'b100,
		SSPS_RD_ACK = 3'b101,
		SSPS_IGNORE = 3'b110
	} ssps_state_t;

	// layout of the sync_serial_status register, msb first
	typedef struct packed {
		logic samplePhaseSelect;
		logic clockEdgeSelect;
		logic dataNotAddress;
		logic stopSeen;
		logic startSeen;
		logic readNotWrite;
		logic addressUpdateRequest;
		logic bufferFullFlag;
	} ssps_status_t;

	// link pins after synchronisation
	typedef struct packed {
		logic scl;
		logic sda;
		logic sck;
		logic sdi;
		logic ssN;
	} ssps_pins_t;

endpackage

/* verilog/ssps_sync.sv */
`timescale 1ns/1ps
module ssps_sync #(
	parameter int WIDTH = 5
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] meta_q;

	initial begin
		if (WIDTH < 1) $error("ssps_sync: WIDTH must be at least 1");
	end

	// two stages; the first stage feeds only the second
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_q <= '0;
			syncOut <= '0;
		end else begin
			meta_q <= asyncIn;
			syncOut <= meta_q;
		end
	end

endmodule

/* verilog/ssps_irq.sv */
`timescale 1ns/1ps
module ssps_irq #(
	parameter int WIDTH = 3
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] eventPulse,
	input wire logic [WIDTH-1:0] clearPulse,
	input wire logic enableWrite,
	input wire logic [WIDTH-1:0] enableData,
	output logic [WIDTH-1:0] status,
	output logic [WIDTH-1:0] enable,
	output logic irq
);

	initial begin
		if (WIDTH < 1 || WIDTH > 32) $error("ssps_irq: WIDTH out of range");
	end

	// sticky flags: a new event in the clearing cycle survives the clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status <= '0;
		end else begin
			status <= (status & ~clearPulse) | eventPulse;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			enable <= '0;
		end else if (enableWrite) begin
			enable <= enableData;
		end
	end

	// level output, one cycle behind the flags
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & enable);
		end
	end

endmodule

/* verilog/ssps_top.sv */
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
// Overview of operation
// - port runs either SPI or I2C, never both
// - status byte at 94h, top two bits writable
// - every status bit clears to zero at reset
// - direction bit held until start, stop, not-acknowledge
module ssps_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic sckIn,
	input wire logic sdiIn,
	input wire logic ssN,
	output logic irq
);

	ssps_pkg::ssps_pins_t pinsAsync;
	ssps_pkg::ssps_pins_t pins;
	ssps_pkg::ssps_pins_t pinsLast_q;
	ssps_pkg::ssps_status_t status_q;
	ssps_pkg::ssps_state_t state_q;
	logic [15:0] ctrl_q;
	logic [7:0] shift_q;
	logic [7:0] buffer_q;
	logic [3:0] bitCount_q;
	logic wrPending_q;
	logic [7:0] wrAddr_q;
	logic [2:0] irqStatus;
	logic [2:0] irqEnable;
	logic [2:0] irqClear;
	logic [2:0] events;
	logic irqEnWrite;
	logic irqLine;
	logic busAccess;
	logic busRead;
	logic bufferRead;
	logic byteDone;
	logic byteIsData;
	logic enabled;
	logic i2cMode;
	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;
	logic sckSample;
	logic [7:0] nextShift;

	// true when a register offset is addressed by the current transfer
	function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
		hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
	endfunction

	// every link pin crosses into the clk domain through two flops
	assign pinsAsync = '{scl: sclIn, sda: sdaIn, sck: sckIn, sdi: sdiIn, ssN: ssN};

	ssps_sync #(
		.WIDTH($bits(ssps_pkg::ssps_pins_t))
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.asyncIn(pinsAsync),
		.syncOut(pins)
	);

	// previous synchronised levels for edge detection
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pinsLast_q <= '1;
		end else begin
			pinsLast_q <= pins;
		end
	end

	// edges and bus conditions, only from the second sync stage
	assign enabled = ctrl_q[ssps_pkg::CTRL_ENABLE_BIT];
	assign i2cMode = (ctrl_q[ssps_pkg::CTRL_MODE_BIT] == ssps_pkg::SSPS_MODE_I2C);
	assign sclRise = pins.scl & ~pinsLast_q.scl;
	assign sclFall = ~pins.scl & pinsLast_q.scl;
	assign startCond = enabled && i2cMode && pins.scl && pinsLast_q.scl
		&& !pins.sda && pinsLast_q.sda;
	assign stopCond = enabled && i2cMode && pins.scl && pinsLast_q.scl
		&& pins.sda && !pinsLast_q.sda;
	// spi samples on the rising edge when the edge select bit is set, else falling
	assign sckSample = enabled && !i2cMode && !pins.ssN
		&& (status_q.clockEdgeSelect ? (pins.sck & ~pinsLast_q.sck)
			: (~pins.sck & pinsLast_q.sck));
	assign nextShift = {shift_q[6:0], i2cMode ? pins.sda : pins.sdi};

	// ahb address phase decode; the slave is always ready, so hready gates it
	assign busAccess = hsel && hready && htrans[1];
	assign busRead = busAccess && !hwrite;
	assign bufferRead = busRead && hit(haddr, ssps_pkg::ADDR_DATA);

	// capture write address phase, data follows in the next cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wrPending_q <= 1'b0;
			wrAddr_q <= 8'h00;
		end else begin
			wrPending_q <= busAccess && hwrite && (haddr[31:8] == 24'h000000);
			wrAddr_q <= haddr[7:0];
		end
	end

	// zero wait states and an always OKAY response
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// read data is registered at the address phase so it stands in the data phase
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hrdata <= 32'h00000000;
		end else if (busRead) begin
			if (hit(haddr, ssps_pkg::ADDR_CTRL)) begin
				hrdata <= {16'h0000, ctrl_q};
			end else if (hit(haddr, ssps_pkg::ADDR_DATA)) begin
				hrdata <= {24'h000000, buffer_q};
			end else if (hit(haddr, ssps_pkg::ADDR_IRQ_STATUS)) begin
				hrdata <= {29'h00000000, irqStatus};
			end else if (hit(haddr, ssps_pkg::ADDR_IRQ_ENABLE)) begin
				hrdata <= {29'h00000000, irqEnable};
			end else if (hit(haddr, ssps_pkg::ADDR_SYNC_SERIAL_STATUS)) begin
				hrdata <= {24'h000000, status_q};
			end else begin
				hrdata <= 32'h00000000; // unmapped and write-only offsets read zero
			end
		end
	end

	// control register; switching mode mid-frame is the user's hazard
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_q <= ssps_pkg::CTRL_RESET;
		end else if (wrPending_q && wrAddr_q == ssps_pkg::ADDR_CTRL) begin
			ctrl_q <= hwdata[15:0];
		end
	end

	// the writable pair of the status register; the low six bits ignore writes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_q.samplePhaseSelect <= 1'b0;
			status_q.clockEdgeSelect <= 1'b0;
		end else if (wrPending_q && wrAddr_q == ssps_pkg::ADDR_SYNC_SERIAL_STATUS) begin
			status_q.samplePhaseSelect <= hwdata[7];
			status_q.clockEdgeSelect <= hwdata[6];
		end
	end

	// ten-bit addressing is not built, so no address update is ever requested
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_q.addressUpdateRequest <= 1'b0;
		end else begin
			status_q.addressUpdateRequest <= 1'b0;
		end
	end

	// start and stop flags: each is cleared when the other is seen, the port is off or the port is in spi mode
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_q.startSeen <= 1'b0;
			status_q.stopSeen <= 1'b0;
		end else if (!enabled || !i2cMode) begin
			status_q.startSeen <= 1'b0;
			status_q.stopSeen <= 1'b0;
		end else if (startCond) begin
			status_q.startSeen <= 1'b1;
			status_q.stopSeen <= 1'b0;
		end else if (stopCond) begin
			status_q.startSeen <= 1'b0;
			status_q.stopSeen <= 1'b1;
		end
	end

	// i2c slave receive sequence with address match and acknowledge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= ssps_pkg::SSPS_IDLE;
		end else if (!enabled || !i2cMode || stopCond) begin
			state_q <= ssps_pkg::SSPS_IDLE;
		end else if (startCond) begin
			state_q <= ssps_pkg::SSPS_ADDR; // repeated start restarts the frame
		end else begin
			case (state_q)
				ssps_pkg::SSPS_IDLE: begin
					state_q <= ssps_pkg::SSPS_IDLE;
				end
				ssps_pkg::SSPS_ADDR: begin
					if (sclRise && bitCount_q == ssps_pkg::BITS_PER_BYTE - 4'h1) begin
						state_q <= (nextShift[7:1] == ctrl_q[ssps_pkg::CTRL_ADDR_LSB +: 7])
							? ssps_pkg::SSPS_ACK_WAIT : ssps_pkg::SSPS_IGNORE;
					end
				end
				ssps_pkg::SSPS_ACK_WAIT: begin
					if (sclFall) begin
						state_q <= ssps_pkg::SSPS_ACK_HOLD;
					end
				end
				ssps_pkg::SSPS_ACK_HOLD: begin
					if (sclFall) begin
						state_q <= ssps_pkg::SSPS_DATA;
					end
				end
				ssps_pkg::SSPS_DATA: begin
					if (sclRise && bitCount_q == ssps_pkg::BITS_PER_BYTE - 4'h1) begin
						state_q <= status_q.readNotWrite ? ssps_pkg::SSPS_RD_ACK
							: ssps_pkg::SSPS_ACK_WAIT;
					end
				end
				ssps_pkg::SSPS_RD_ACK: begin
					if (sclRise) begin
						state_q <= pins.sda ? ssps_pkg::SSPS_IGNORE : ssps_pkg::SSPS_DATA;
					end
				end
				ssps_pkg::SSPS_IGNORE: begin
					state_q <= ssps_pkg::SSPS_IGNORE;
				end
				default: begin
					state_q <= ssps_pkg::SSPS_IDLE;
				end
			endcase
		end
	end

	// direction bit: taken on address match, dropped on start, stop or nack
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_q.readNotWrite <= 1'b0;
		end else if (!enabled || !i2cMode || startCond || stopCond) begin
			status_q.readNotWrite <= 1'b0;
		end else if (state_q == ssps_pkg::SSPS_RD_ACK && sclRise && pins.sda) begin
			status_q.readNotWrite <= 1'b0;
		end else if (state_q == ssps_pkg::SSPS_ADDR && sclRise
			&& bitCount_q == ssps_pkg::BITS_PER_BYTE - 4'h1
			&& nextShift[7:1] == ctrl_q[ssps_pkg::CTRL_ADDR_LSB +: 7]) begin
			status_q.readNotWrite <= nextShift[0];
		end
	end

	// shift register and bit counter shared by both protocols
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			shift_q <= 8'h00;
			bitCount_q <= 4'h0;
		end else if (startCond || (!i2cMode && pins.ssN) || !enabled) begin
			bitCount_q <= 4'h0; // a frame boundary drops any partial byte
		end else if (sckSample || (sclRise && (state_q == ssps_pkg::SSPS_ADDR
			|| state_q == ssps_pkg::SSPS_DATA))) begin
			shift_q <= nextShift;
			bitCount_q <= (bitCount_q == ssps_pkg::BITS_PER_BYTE - 4'h1) ? 4'h0
				: bitCount_q + 4'h1;
		end
	end

	// a byte is done on its eighth sample; in i2c only written data bytes count
	assign byteDone = (bitCount_q == ssps_pkg::BITS_PER_BYTE - 4'h1) && (sckSample
		|| (sclRise && state_q == ssps_pkg::SSPS_DATA && !status_q.readNotWrite));
	assign byteIsData = byteDone && i2cMode;

	// the receive buffer loads from the shifter when a byte completes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			buffer_q <= 8'h00;
		end else if (byteDone) begin
			buffer_q <= nextShift;
		end
	end

	// buffer full: a load in the cycle of a buffer read wins over the clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_q.bufferFullFlag <= 1'b0;
		end else if (byteDone) begin
			status_q.bufferFullFlag <= 1'b1;
		end else if (bufferRead || !enabled) begin
			status_q.bufferFullFlag <= 1'b0;
		end
	end

	// data or address indication of the last i2c byte
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_q.dataNotAddress <= 1'b0;
		end else if (!enabled || !i2cMode || startCond) begin
			status_q.dataNotAddress <= 1'b0;
		end else if (byteIsData) begin
			status_q.dataNotAddress <= 1'b1;
		end
	end

	// acknowledge: pull sda low for the ninth clock; released after it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sdaOe <= 1'b0;
			sdaOut <= 1'b0;
		end else begin
			sdaOe <= (state_q == ssps_pkg::SSPS_ACK_HOLD) && enabled && i2cMode;
			sdaOut <= 1'b0; // open drain: only ever drives low
		end
	end

	// interrupt events and register access strobes
	assign events = {stopCond, startCond, byteDone};
	assign irqClear = (wrPending_q && wrAddr_q == ssps_pkg::ADDR_IRQ_CLEAR)
		? hwdata[2:0] : 3'h0;
	assign irqEnWrite = wrPending_q && wrAddr_q == ssps_pkg::ADDR_IRQ_ENABLE;

	ssps_irq #(
		.WIDTH(ssps_pkg::IRQ_COUNT)
	) u_irq (
		.clk(clk),
		.sys_rst(sys_rst),
		.eventPulse(events),
		.clearPulse(irqClear),
		.enableWrite(irqEnWrite),
		.enableData(hwdata[2:0]),
		.status(irqStatus),
		.enable(irqEnable),
		.irq(irqLine)
	);

	// the irq block output is already a flop; this keeps the port registered here
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= irqLine;
		end
	end

endmodule

/* bench/ssps_asserts.sv */
`timescale 1ns/1ps
module ssps_asserts (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic irq
);
	logic take;
	logic wCtrl_q;
	logic i2cOn_q;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// address phase accepted by the slave
	assign take = hsel && hready && htrans[1];
	// a control write is pending in its data phase
	always_ff @(posedge clk) begin
		wCtrl_q <= !sys_rst && take && hwrite && haddr[7:0] == ssps_pkg::ADDR_CTRL;
	end
	// shadow of i2c mode plus enable, so the ack can be tied to the mode
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			i2cOn_q <= 1'b0;
		end else if (wCtrl_q) begin
			i2cOn_q <= hwdata[0] && hwdata[1];
		end
	end
	a_reset_clear: assert property (disable iff (1'b0)
		sys_rst |=> hrdata == 32'h0 && !irq && !sdaOe && hreadyout)
		else $error("outputs not cleared by reset");
	a_ready_okay: assert property (hreadyout && !hresp)
		else $error("slave stalled or answered an error");
	a_status_upper: assert property (take && !hwrite && haddr == 32'h94
		|=> hrdata[31:8] == 24'h0 && !hrdata[1])
		else $error("status read shows bits outside its byte");
	a_data_byte: assert property (take && !hwrite && haddr == 32'h04
		|=> hrdata[31:8] == 24'h0)
		else $error("buffer read wider than a byte");
	a_ack_mode: assert property (sdaOe |-> i2cOn_q && !sdaOut)
		else $error("data line pulled outside enabled i2c mode");
	a_ack_hold: assert property ($rose(sdaOe) |-> sdaOe [*6])
		else $error("acknowledge released too early");
endmodule
bind ssps_top ssps_asserts u_ssps_asserts (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sdaOut(sdaOut), .sdaOe(sdaOe),
	.irq(irq));

/* bench/ssps_peer.sv */
`timescale 1ns/1ps
module ssps_peer (
	input wire logic clk,
	input wire logic sdaBus,
	output logic scl,
	output logic sdaLow,
	output logic sck,
	output logic sdi,
	output logic ssN
);
	logic ackSeen;
	// idle bus: clocks stand still, data released to the pull-up
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
		sck = 1'b0;
		sdi = 1'b0;
		ssN = 1'b1;
		ackSeen = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one link clock of 8 system clocks; data moves mid low phase
	task automatic bitOut(input logic b);
		sdaLow <= !b;
		w(2);
		scl <= 1'b1;
		w(2);
		ackSeen = !sdaBus;
		w(2);
		scl <= 1'b0;
		w(2);
	endtask
	// eight bits msb first, then a released ninth clock for the ack
	task automatic sendByte(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			bitOut(d[i]);
		end
		bitOut(1'b1);
	endtask
	task automatic start();
		sdaLow <= 1'b1;
		w(4);
		scl <= 1'b0;
		w(2);
	endtask
	task automatic stop();
		sdaLow <= 1'b1;
		w(2);
		scl <= 1'b1;
		w(4);
		sdaLow <= 1'b0;
		w(4);
	endtask
	task automatic spiByte(input logic [7:0] d);
		ssN <= 1'b0;
		w(4);
		for (int i = 7; i >= 0; i--) begin
			sdi <= d[i];
			w(2);
			sck <= 1'b1;
			w(4);
			sck <= 1'b0;
			w(2);
		end
		ssN <= 1'b1;
		sdi <= !d[0]; // deselected line must not keep its last bit
		w(4);
	endtask
endmodule

/* bench/sync_serial_port_status_test.sv */
`timescale 1ns/1ps
module sync_serial_port_status_test;
	localparam logic [7:0] CT = ssps_pkg::ADDR_CTRL;
	localparam logic [7:0] DT = ssps_pkg::ADDR_DATA;
	localparam logic [7:0] IS = ssps_pkg::ADDR_IRQ_STATUS;
	localparam logic [7:0] IC = ssps_pkg::ADDR_IRQ_CLEAR;
	localparam logic [7:0] IE = ssps_pkg::ADDR_IRQ_ENABLE;
	localparam logic [7:0] ST = ssps_pkg::ADDR_SYNC_SERIAL_STATUS;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic [31:0] v;
	logic hreadyout, hresp, sdaOut, sdaOe, irq, scl, sdaLow, sck, sdi, ssN, sdaBus;
	int n_errors = 0;
	int cmp_count = 0;
	// open-drain data line with pull-up
	assign sdaBus = !(sdaLow || (sdaOe && !sdaOut));
	always #10 clk = ~clk;
	ssps_top u_ssps_top (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sclIn(scl), .sdaIn(sdaBus),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .sckIn(sck), .sdiIn(sdi), .ssN(ssN), .irq(irq));
	ssps_peer u_ssps_peer (.clk(clk), .sdaBus(sdaBus), .scl(scl), .sdaLow(sdaLow),
		.sck(sck), .sdi(sdi), .ssN(ssN));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// bounded wait for hready at a rising edge
	task automatic rdy();
		int k;
		k = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1 && k < 64) begin
			k++;
			@(posedge clk);
		end
		if (k == 64) n_errors++;
	endtask
	// one single word transfer; read data lands in v
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		haddr <= {24'h0, a};
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		v = hrdata;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(v, e);
	endtask
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// hang guard: the whole run needs well under 10000 cycles
	initial begin
		#400000;
		n_errors++;
		wrap_up();
	end
	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		rc(ST, 32'h0);
		bus(1'b1, ST, 32'hff);
		rc(ST, 32'hc0);
		rc(8'h20, 32'h0);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk);
		rc(ST, 32'h0);
		$display("registers done");
		bus(1'b1, CT, 32'h2a03);
		bus(1'b1, IE, 32'h7);
		u_ssps_peer.start();
		rc(ST, 32'h08);
		u_ssps_peer.sendByte(8'h54);
		chk({31'h0, u_ssps_peer.ackSeen}, 32'h1);
		u_ssps_peer.sendByte(8'ha5);
		rc(ST, 32'h29);
		chk({31'h0, irq}, 32'h1);
		rc(IS, 32'h3);
		rc(DT, 32'ha5);
		rc(ST, 32'h28);
		u_ssps_peer.stop();
		bus(1'b0, ST, 32'h0);
		chk(v & 32'h1f, 32'h10);
		bus(1'b1, IC, 32'h7);
		rc(IS, 32'h0);
		// irq trails the cleared flags by two flops, so let one more edge pass
		@(posedge clk);
		chk({31'h0, irq}, 32'h0);
		$display("i2c write done");
		u_ssps_peer.start();
		u_ssps_peer.sendByte(8'h55);
		bus(1'b0, ST, 32'h0);
		chk(v & 32'h4, 32'h4);
		u_ssps_peer.sendByte(8'hff);
		bus(1'b0, ST, 32'h0);
		chk(v & 32'h5, 32'h0);
		u_ssps_peer.stop();
		$display("i2c direction done");
		bus(1'b1, CT, 32'h2);
		bus(1'b1, IC, 32'h7);
		bus(1'b1, IE, 32'h0);
		u_ssps_peer.start();
		u_ssps_peer.stop();
		u_ssps_peer.spiByte(8'h3c);
		rc(ST, 32'h01);
		chk({31'h0, irq}, 32'h0);
		rc(IS, 32'h1);
		rc(DT, 32'h3c);
		rc(ST, 32'h00);
		// edge select set: spi now samples on the rising clock edge
		bus(1'b1, ST, 32'h40);
		u_ssps_peer.spiByte(8'hc3);
		rc(ST, 32'h41);
		rc(DT, 32'hc3);
		rc(ST, 32'h40);
		$display("spi done");
		wrap_up();
	end
endmodule
